// ### core/wdt_core.sv
// Purpose: watchdog and interval timer with ahb-lite register access
// Assumes: hclk is the cpu clock; rc oscillator arrives as a pin
// Notes:
// Operation
// - watchdog reset holds internal reset for about one microsecond
// - running cpu clock: execution restarts right after the pulse
// - from power-down: start oscillator, resume only once it is stable
// - watchdog reset leaves control register at 30H
// - other reset with fuse enabled leaves control at 10H
// - other reset with fuse disabled leaves control at 00H
// - bit 5 overflow flag set on overflow or watchdog reset
// - valid feed clears the overflow flag
// - bit 4 run control starts and halts the counter
// - fuse at 1 forces run control to 1
// - bit 3 picks cpu clock divided by 6 or rc oscillator
// - fuse at 1 forces clock select to 0
// - rate code 0 gives 8192 counts, doubling up to 1048576
// - wrong or partial feed changes nothing in the schedule
// - fuse at 0 turns off reset, leaves interval timer with interrupt
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module wdt_core
	import wdt_pkg::*;
#(
	parameter int unsigned BASE_TICKS = BASE_TICKS_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic fuse_pin,
	input wire logic rc_osc_pin,
	input wire logic powerdown_pin,
	input wire logic osc_stable_pin,
	output logic chip_reset_req,
	output logic osc_start,
	output logic cpu_hold,
	output logic irq
);

	wdt_regs_s q;
	wdt_regs_s next_q;
	logic [3:0] pins_s;
	logic fuse_s;
	logic rc_s;
	logic pd_s;
	logic osc_ok_s;
	logic wr;
	logic wr_ctl;
	logic wr_feed;
	logic wr_istat;
	logic wr_imask;
	logic feed_ok;
	logic tick;
	logic ovf_evt;
	logic ctl_ok;
	logic [CNT_W-1:0] lim_m1;
	logic [7:0] ctl_byte;

	// all pins cross into hclk through two flops
	wdt_sync #(
		.W(4)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({osc_stable_pin, powerdown_pin, rc_osc_pin, fuse_pin}),
		.q(pins_s)
	);

	assign fuse_s = pins_s[0];
	assign rc_s = pins_s[1];
	assign pd_s = pins_s[2];
	assign osc_ok_s = pins_s[3];

	// last count before overflow for the selected rate
	assign lim_m1 = CNT_W'((CNT_W'(BASE_TICKS) << q.rate) - CNT_W'(1));

	// bus write decode in the data phase; hsize ignored, full words only
	assign wr = q.a_valid && q.a_write;
	assign wr_ctl = wr && (q.a_word == CTL_IDX);
	assign wr_feed = wr && (q.a_word == FEED_IDX);
	assign wr_istat = wr && (q.a_word == ISTAT_IDX);
	assign wr_imask = wr && (q.a_word == IMASK_IDX);

	// once fused on, the first control write after a reset is the last one
	assign ctl_ok = q.init_done && !(fuse_s && q.wrote);

	// feed completes on key two after key one; writes to other registers between are allowed, any other feed value disarms
	assign feed_ok = wr_feed && q.armed && (hwdata[7:0] == FEED_KEY2);

	// one count clock: cpu/6 prescaler or rising edge of the rc oscillator
	assign tick = (q.st == ST_RUN) && q.init_done && q.run
		&& (q.clk_sel ? (q.pre == PRE_LAST) : (rc_s && !q.rc_d));

	assign ovf_evt = tick && (q.cnt >= lim_m1);

	assign ctl_byte = {2'h0, q.ovf, q.run, q.clk_sel, q.rate};

	// next-state logic for the whole block
	always_comb begin
		next_q = q;

		// wait for the synchronisers, then load the fuse-dependent value
		if (!q.init_done) begin
			next_q.init_cnt = q.init_cnt + 2'h1;
			if (q.init_cnt == INIT_WAIT) begin
				next_q.init_done = 1'b1;
				next_q.run = fuse_s;
			end
		end

		// address phase capture; slave never inserts wait states
		next_q.a_valid = hsel && htrans[1] && hready;
		next_q.a_write = hwrite;
		next_q.a_word = haddr[ADDR_W-1:2];

		// control write; overflow flag is hardware owned
		if (wr_ctl && ctl_ok) begin
			next_q.run = hwdata[RUN_BIT];
			next_q.clk_sel = hwdata[CSEL_BIT];
			next_q.rate = hwdata[RATE_LSB +: RATE_W];
			if (fuse_s) begin
				next_q.wrote = 1'b1;
			end
		end

		// feed sequencer; a stray value only disarms, the count goes on
		if (wr_feed) begin
			if (hwdata[7:0] == FEED_KEY1) begin
				next_q.armed = 1'b1;
			end else begin
				next_q.armed = 1'b0;
			end
		end

		// fuse locks the watchdog running from the rc oscillator
		if (fuse_s && q.init_done) begin
			next_q.run = 1'b1;
			next_q.clk_sel = 1'b0;
		end

		// interrupt registers; clears come first so a same-cycle set wins
		if (wr_istat) begin
			next_q.int_stat = q.int_stat & ~hwdata[INT_W-1:0];
		end
		if (wr_imask) begin
			next_q.int_mask = hwdata[INT_W-1:0];
		end

		// free-running divide-by-6 and rc edge history
		next_q.pre = (q.pre == PRE_LAST) ? 3'h0 : q.pre + 3'h1;
		next_q.rc_d = rc_s;

		// valid feed restarts the count and drops the flag
		if (feed_ok) begin
			next_q.cnt = '0;
			next_q.ovf = 1'b0;
		end else if (tick && !ovf_evt) begin
			next_q.cnt = q.cnt + CNT_W'(1);
		end

		// overflow: flag always; chip reset and INT_FEED_REGISTER status if enabled, INT_OVF status otherwise
		if (ovf_evt) begin
			next_q.cnt = '0;
			next_q.ovf = 1'b1;
			if (fuse_s) begin
				next_q.st = ST_RESET;
				next_q.pulse = PULSE_LAST;
				next_q.rst_req = 1'b1;
				next_q.cpu_hold = 1'b1;
				next_q.pd_lat = pd_s;
				next_q.int_stat[INT_FEED_REGISTER] = 1'b1;
			end else begin
				next_q.int_stat[INT_OVF] = 1'b1;
			end
		end

		// watchdog reset sequencing
		case (q.st)
			ST_RUN: begin
			end
			ST_RESET: begin
				// register forced to its after-watchdog-reset image
				next_q.cnt = '0;
				next_q.ovf = CTL_WDT_RESET[OVF_BIT];
				next_q.run = CTL_WDT_RESET[RUN_BIT];
				next_q.clk_sel = CTL_WDT_RESET[CSEL_BIT];
				next_q.rate = CTL_WDT_RESET[RATE_LSB +: RATE_W];
				next_q.wrote = 1'b0;
				next_q.armed = 1'b0;
				if (q.pulse == 5'h0) begin
					next_q.rst_req = 1'b0;
					if (q.pd_lat) begin
						next_q.st = ST_OSC;
						next_q.osc_start = 1'b1;
					end else begin
						next_q.st = ST_RUN;
						next_q.cpu_hold = 1'b0;
					end
				end else begin
					next_q.pulse = q.pulse - 5'h1;
				end
			end
			ST_OSC: begin
				// hold the cpu until the restarted oscillator settles
				if (osc_ok_s) begin
					next_q.st = ST_RUN;
					next_q.osc_start = 1'b0;
					next_q.cpu_hold = 1'b0;
				end
			end
			default: begin
				next_q.st = ST_RUN;
			end
		endcase

		// read data from the next state so read-after-write sees the write
		next_q.rdata = 32'h0;
		if (hsel && htrans[1] && hready && !hwrite) begin
			case (haddr[ADDR_W-1:2])
				CTL_IDX: begin
					next_q.rdata = {24'h0, 2'h0, next_q.ovf, next_q.run,
						next_q.clk_sel, next_q.rate};
				end
				ISTAT_IDX: begin
					next_q.rdata = {30'h0, next_q.int_stat};
				end
				IMASK_IDX: begin
					next_q.rdata = {30'h0, next_q.int_mask};
				end
				default: begin
					next_q.rdata = 32'h0;
				end
			endcase
		end

		// level interrupt while any unmasked status bit is set
		next_q.irq = |(next_q.int_stat & next_q.int_mask);
		next_q.ready = 1'b1;
		next_q.resp = 1'b0;
	end

	// single state register; hreadyout comes up high out of reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.ready <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// every output straight from a flop
	assign hrdata = q.rdata;
	assign hreadyout = q.ready;
	assign hresp = q.resp;
	assign chip_reset_req = q.rst_req;
	assign osc_start = q.osc_start;
	assign cpu_hold = q.cpu_hold;
	assign irq = q.irq;

	// checks on the documented behaviour
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_pulse_body;
		chip_reset_req ##19 chip_reset_req ##1 !chip_reset_req;
	endsequence

	sequence s_restart;
		$fell(chip_reset_req) && !osc_start;
	endsequence

	a_reset_pulse_len: assert property (
		$rose(chip_reset_req) |-> s_pulse_body)
		else $error("watchdog reset pulse length wrong");

	a_restart_no_delay: assert property (
		s_restart |-> !cpu_hold)
		else $error("cpu held after reset pulse with clock running");

	a_osc_wait_hold: assert property (
		osc_start && !osc_ok_s |=> cpu_hold)
		else $error("cpu released before oscillator stable");

	a_wdt_reset_value: assert property (
		$fell(chip_reset_req) |-> ctl_byte == CTL_WDT_RESET)
		else $error("control not 30h after watchdog reset");

	a_init_value: assert property (
		$rose(q.init_done) |->
		ctl_byte == ($past(fuse_s) ? CTL_FUSE_ON : CTL_FUSE_OFF))
		else $error("control value after reset wrong");

	a_ovf_flag_set: assert property (
		ovf_evt |=> q.ovf)
		else $error("overflow flag not set on overflow");

	a_feed_restart: assert property (
		feed_ok && !ovf_evt && q.st == ST_RUN |=> q.cnt == '0 && !q.ovf)
		else $error("valid feed did not restart count");

	a_run_halts: assert property (
		!q.run && !feed_ok && q.st == ST_RUN |=> $stable(q.cnt))
		else $error("counter moved while halted");

	a_fuse_forces: assert property (
		fuse_s && q.init_done |=> q.run && !q.clk_sel)
		else $error("fuse did not force run and rc clock");

	a_cpu_div_tick: assert property (
		tick && q.clk_sel |=> (!tick || !q.clk_sel) [*5])
		else $error("cpu clock tick not divided by 6");

	a_limit_reached: assert property (
		ovf_evt |-> q.cnt == lim_m1 || q.cnt > lim_m1)
		else $error("overflow before selected length");

	a_write_once: assert property (
		wr_ctl && fuse_s && q.wrote && q.st == ST_RUN |=>
		q.rate == $past(q.rate))
		else $error("second control write accepted");

	a_ovf_reset: assert property (
		ovf_evt && fuse_s |=> chip_reset_req)
		else $error("enabled overflow did not request reset");

	a_ovf_intr: assert property (
		ovf_evt && !fuse_s && q.int_mask[INT_OVF] |=> ##1 irq && !chip_reset_req)
		else $error("interval overflow did not raise interrupt");

endmodule
`default_nettype wire

// ### core/wdt_pkg.sv
// Purpose: shared constants and types for the watchdog / interval timer
// Assumes: 32-bit ahb-lite register bus, hclk at 20 MHz
// Notes: register word index times four is the byte address
`default_nettype none
package wdt_pkg;

	// bus geometry
	localparam int ADDR_W = 12;
	localparam int WORD_W = 10;

	// register word indexes; byte address is four times the index
	localparam logic [WORD_W-1:0] CTL_IDX = 10'h0a7;
	localparam logic [WORD_W-1:0] FEED_IDX = 10'h0a8;
	localparam logic [WORD_W-1:0] ISTAT_IDX = 10'h0a9;
	localparam logic [WORD_W-1:0] IMASK_IDX = 10'h0aa;

	// control register fields
	localparam int OVF_BIT = 5;
	localparam int RUN_BIT = 4;
	localparam int CSEL_BIT = 3;
	localparam int RATE_LSB = 0;
	localparam int RATE_W = 3;

	// control register values after the various resets
	localparam logic [7:0] CTL_WDT_RESET = 8'h30;
	localparam logic [7:0] CTL_FUSE_ON = 8'h10;
	localparam logic [7:0] CTL_FUSE_OFF = 8'h00;

	// feed keys
	localparam logic [7:0] FEED_KEY1 = 8'h1e;
	localparam logic [7:0] FEED_KEY2 = 8'he1;

	// interrupt status bits
	localparam int INT_W = 2;
	localparam int INT_OVF = 0;
	localparam int INT_FEED_REGISTER = 1;

	// count geometry: 8192 count clocks doubled up to seven times
	localparam int unsigned BASE_TICKS_DEF = 8192;
	localparam int CNT_W = 21;
	localparam logic [2:0] PRE_LAST = 3'h5;

	// timing of the internal reset pulse
	localparam int CLK_PERIOD_NS = 50;
	localparam int RST_PULSE_NS = 1000;
	localparam int RST_CYCLES_RAW =
		(RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CYCLES = (RST_CYCLES_RAW < 1) ? 1 : RST_CYCLES_RAW;
	localparam logic [4:0] PULSE_LAST = 5'(RST_CYCLES - 1);

	// cycles spent filling the pin synchronisers after hresetn release
	localparam logic [1:0] INIT_WAIT = 2'h2;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_RESET,
		ST_OSC
	} wdt_state_e;

	typedef struct packed {
		wdt_state_e st;
		logic [1:0] init_cnt;
		logic init_done;
		logic ovf;
		logic run;
		logic clk_sel;
		logic [RATE_W-1:0] rate;
		logic wrote;
		logic armed;
		logic [CNT_W-1:0] cnt;
		logic [2:0] pre;
		logic rc_d;
		logic [4:0] pulse;
		logic pd_lat;
		logic [INT_W-1:0] int_stat;
		logic [INT_W-1:0] int_mask;
		logic a_valid;
		logic a_write;
		logic [WORD_W-1:0] a_word;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		logic rst_req;
		logic osc_start;
		logic cpu_hold;
		logic irq;
	} wdt_regs_s;

endpackage
`default_nettype wire

// ### core/wdt_sync.sv
// Purpose: two-flop synchroniser for pins from outside the hclk domain
// Assumes: inputs are slow levels or slow clocks
// Notes: only the second stage is visible outside
`timescale 1ns/100ps
`default_nettype none
module wdt_sync #(
	parameter int W = 1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} wdt_sync_s;

	wdt_sync_s r;
	wdt_sync_s next_r;

	// first stage feeds the second stage and nothing else
	always_comb begin
		next_r = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;

endmodule
`default_nettype wire

// ### dv/watchdog_timer_control_bench.sv
// Purpose: self-checking bench for the watchdog / interval timer
// Assumes: no wait states; BASE_TICKS cut to 16 so runs stay short
// Notes: rc oscillator pin toggles at random slow rates from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_control_bench import wdt_pkg::*;;
	localparam int BT = 16;
	logic hclk, hresetn, hsel, hwrite;
	logic fuse_pin, rc_osc_pin, powerdown_pin, osc_stable_pin, rc_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, chip_reset_req, osc_start, cpu_hold, irq;
	int seed, miscompares, checked, cyc, t0, n, rc_cnt;
	logic [7:0] bad;

	wdt_core #(.BASE_TICKS(BT)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.fuse_pin(fuse_pin), .rc_osc_pin(rc_osc_pin),
		.powerdown_pin(powerdown_pin), .osc_stable_pin(osc_stable_pin),
		.chip_reset_req(chip_reset_req), .osc_start(osc_start),
		.cpu_hold(cpu_hold), .irq(irq));

	// clock at 50 ns
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// free cycle count and slow rc oscillator with random half periods
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (rc_en && rc_cnt == 0) begin
			rc_osc_pin <= ~rc_osc_pin;
			rc_cnt <= 2 + ($random(seed) & 3);
		end else if (rc_cnt > 0) begin
			rc_cnt <= rc_cnt - 1;
		end
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_win(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("[ERR] %0t span %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// address phase held until hready, then data phase until hready
	task automatic ahb(input logic w, input logic [9:0] idx,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {20'h0, idx, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		k = 0;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		htrans <= 2'b00;
		hwdata <= d;
		k = 0;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 50);
		q = hrdata;
		// no wait states and always an okay answer
		chk({30'h0, hreadyout, hresp}, 32'h2);
		hsel <= 1'b0;
	endtask

	// control byte as software should read it back
	function automatic logic [31:0] ctl_val(input logic o, input logic run,
		input logic cs, input int r);
		logic [31:0] v;
		v = '0;
		v[OVF_BIT] = o;
		v[RUN_BIT] = run;
		v[CSEL_BIT] = cs;
		v[RATE_LSB +: RATE_W] = r[RATE_W-1:0];
		return v;
	endfunction

	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [31:0] q;
		ahb(1'b1, idx, {24'h0, d}, q);
	endtask

	task automatic feed;
		wr(FEED_IDX, FEED_KEY1);
		wr(FEED_IDX, FEED_KEY2);
	endtask

	function automatic logic pick(input int which);
		return which == 0 ? irq : which == 1 ? chip_reset_req : ~cpu_hold;
	endfunction

	// look only at edges after the call, never at a value about to change
	task automatic wait_for(input int which, input int lim, output int k);
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (pick(which) !== 1'b1 && k < lim);
	endtask

	task automatic do_reset(input logic f);
		hresetn <= 1'b0;
		fuse_pin <= f;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (6) @(posedge hclk);
	endtask

	// count the reset pulse and check its length against RST_CYCLES
	task automatic pulse_len;
		wait_for(1, 3000, n);
		n = 0;
		while (chip_reset_req === 1'b1 && n < 100) begin
			@(posedge hclk);
			n++;
		end
		chk_win(n, RST_CYCLES, RST_CYCLES);
	endtask

	// interval mode: time one overflow from a feed at cpu clock / 6
	task automatic ovf_time(input int r, input int extra);
		int lim;
		lim = (BT << r) * 6 + extra;
		wait_for(0, lim + 40, n);
		chk_win(cyc - t0, lim - 8, lim + 12);
	endtask

	initial begin
		seed = 22793;
		{hresetn, hsel, hwrite, rc_en, rc_osc_pin} = '0;
		{powerdown_pin, osc_stable_pin, fuse_pin} = '0;
		{haddr, hwdata, htrans, hsize, cyc, rc_cnt, miscompares} = '0;
		checked = 0;
		hsize = 3'b010;
		do_reset(1'b0);
		ahb(1'b0, CTL_IDX, '0, rd);
		chk(rd, CTL_FUSE_OFF);
		wr(10'h0b0, 8'hff);
		ahb(1'b0, 10'h0b0, '0, rd);
		chk(rd, 32'h0);
		wr(IMASK_IDX, 8'h01);
		// every rate code in turn
		for (int r = 0; r < 8; r++) begin
			wr(CTL_IDX, 8'h18 | r[7:0]);
			feed();
			t0 = cyc;
			wr(ISTAT_IDX, 8'h03);
			ovf_time(r, 0);
			chk(chip_reset_req, 0);
			ahb(1'b0, CTL_IDX, '0, rd);
			chk(rd, ctl_val(1'b1, 1'b1, 1'b1, r));
			feed();
			ahb(1'b0, CTL_IDX, '0, rd);
			chk(rd, ctl_val(1'b0, 1'b1, 1'b1, r));
		end
		// halted counter never overflows
		wr(CTL_IDX, 8'h08);
		feed();
		wr(ISTAT_IDX, 8'h03);
		wait_for(0, 800, n);
		chk(n, 800);
		// masked event keeps irq low, unmask raises it
		wr(IMASK_IDX, 8'h00);
		wr(CTL_IDX, 8'h1a);
		feed();
		t0 = cyc;
		repeat (500) @(posedge hclk);
		chk(irq, 0);
		wr(IMASK_IDX, 8'h01);
		repeat (2) @(posedge hclk);
		chk(irq, 1);
		// broken feed keeps schedule, good feed restarts it
		feed();
		t0 = cyc;
		wr(ISTAT_IDX, 8'h03);
		repeat (2) @(posedge hclk);
		chk(irq, 0);
		repeat (200) @(posedge hclk);
		bad = $random(seed);
		if (bad == FEED_KEY1 || bad == FEED_KEY2) bad = 8'h55;
		wr(FEED_IDX, FEED_KEY1);
		wr(FEED_IDX, bad);
		wr(FEED_IDX, FEED_KEY2);
		ovf_time(2, 0);
		wr(ISTAT_IDX, 8'h03);
		feed();
		t0 = cyc;
		repeat (200) @(posedge hclk);
		feed();
		ovf_time(2, 200 + 6);
		// watchdog mode: forced bits, single write, rc counting
		do_reset(1'b1);
		ahb(1'b0, CTL_IDX, '0, rd);
		chk(rd, CTL_FUSE_ON);
		wr(CTL_IDX, 8'h09);
		wr(CTL_IDX, 8'h00);
		ahb(1'b0, CTL_IDX, '0, rd);
		chk(rd, ctl_val(1'b0, 1'b1, 1'b0, 1));
		rc_en <= 1'b1;
		pulse_len();
		chk(cpu_hold, 0);
		ahb(1'b0, CTL_IDX, '0, rd);
		chk(rd, CTL_WDT_RESET);
		ahb(1'b0, ISTAT_IDX, '0, rd);
		chk(rd, 32'h2);
		wr(IMASK_IDX, 8'h02);
		repeat (2) @(posedge hclk);
		chk(irq, 1);
		wr(ISTAT_IDX, 8'h02);
		repeat (2) @(posedge hclk);
		chk(irq, 0);
		// overflow while powered down waits for the oscillator
		powerdown_pin <= 1'b1;
		pulse_len();
		repeat (4) @(posedge hclk);
		chk({osc_start, cpu_hold}, 2'b11);
		osc_stable_pin <= 1'b1;
		wait_for(2, 10, n);
		chk_win(n, 1, 6);
		chk(osc_start, 0);
		close_out();
	end

	// hang guard well past the expected run length
	initial begin
		#4000000;
		miscompares++;
		close_out();
	end
endmodule
`default_nettype wire
